// *** core/qss_sequencer.sv ***
// Queue sequencer, halt, loopback and status logic of a queued SPI master.
// Assumes one AHB-Lite master on core_clk; pins are asynchronous to core_clk.
// Summary of operation
// - End-pointer match after command sets done flag
// - Queue has sixteen entries, any pointer value
// - Queue wraps past fifteen to zero
// - At most sixteen commands without wrap
// - Start pointer rewrite takes effect after current
// - End pointer writable anytime, changes termination
// - Wrap with target select jumps to start
// - Loopback feeds serial output back to input
// - Halt/fault enable gates their interrupt
// - Halt completes current transfer, then stops
// - Halted chip-selects: hold pattern or port data
// - Halt in last command: both flags, disable
// - Only hardware sets flags; pointer read-only
// - Done flag per pass; interrupt if enabled
// - Flag cleared by read-set then write-zero
// - Mode fault on low slave-select input
// - Mode fault disables, returns pins to port
// - No fault check when slave-select is output
// - Halt acknowledge flag at orderly stop
// - Completed pointer updates after command completes
// - Three sources share one interrupt output
`timescale 1ns/1ps
`default_nettype none
module qss_sequencer import qss_pkg::*; #(
	parameter int BITS = QSS_BITS,
	parameter int HALF = QSS_SCK_HALF_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [3:0]  pcsOut,
	output logic      [3:0]  pcsOe,
	input  wire logic        slaveSelectIn,
	input  wire logic        misoIn,
	output logic             mosiOut,
	output logic             sckOut,
	output logic             irq
);
	qss_state_type   state;
	logic [3:0]      curIdx;
	logic [3:0]      startPtr;
	logic [3:0]      endPtr;
	logic [3:0]      cptPtr;
	logic [3:0]      portData;
	logic [3:0]      pinDir;
	logic [3:0]      lastPcs;
	logic            lastHold;
	logic            serialEnable;
	logic            masterSelect;
	logic            wrapEnable;
	logic            wrapTarget;
	logic            doneIrqEnable;
	logic            haltFaultIrqEnable;
	logic            halt;
	logic            loopbackEnable;
	logic            startPending;
	logic [2:0]      flags;
	logic [2:0]      seen;
	logic [7:0]      cmdRam [QSS_ENTRIES];
	logic [BITS-1:0] txRam [QSS_ENTRIES];
	logic [BITS-1:0] rxRam [QSS_ENTRIES];
	logic            ssMeta;
	logic            ssSync;
	logic            misoMeta;
	logic            misoSync;
	logic            wrPend;
	logic [7:0]      wrAddr;
	logic            addrPhase;
	logic            wrStart;
	logic            stsWrite;
	logic            stsRead;
	logic            faultEvent;
	logic            isLast;
	logic            stopping;
	logic            hwDisable;
	logic [3:0]      nextIdx;
	logic            shStart;
	logic            shDone;
	logic            shBusy;
	logic            shSck;
	logic            shMosi;
	logic [BITS-1:0] shRx;
	logic [7:0]      curCmd;

	// Pin synchronisers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ssMeta   <= 1'b1;
			ssSync   <= 1'b1;
			misoMeta <= 1'b0;
			misoSync <= 1'b0;
		end else begin
			ssMeta   <= slaveSelectIn;
			ssSync   <= ssMeta;
			misoMeta <= misoIn;
			misoSync <= misoMeta;
		end
	end

	// Bus decode
	assign addrPhase = hsel && htrans[1] && hready;
	assign wrStart   = wrPend && (wrAddr == QSS_OFS_CTRL_TWO);
	assign stsWrite  = wrPend && (wrAddr == QSS_OFS_STATUS);
	assign stsRead   = addrPhase && !hwrite && (haddr[7:0] == QSS_OFS_STATUS);
	assign curCmd    = cmdRam[curIdx];

	assign faultEvent = serialEnable && masterSelect && !pinDir[0] && !ssSync;
	assign isLast     = (curIdx == endPtr);
	assign stopping   = isLast && (!wrapEnable || halt);
	assign hwDisable  = faultEvent || (state == QSS_FINISH && stopping);

	// Next entry: rewrite, wrap target, circular increment
	always_comb begin
		if (startPending) begin
			nextIdx = startPtr;
		end else if (isLast) begin
			nextIdx = wrapTarget ? startPtr : 4'h0;
		end else begin
			nextIdx = curIdx + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrPend    <= 1'b0;
			wrAddr    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wrPend    <= addrPhase && hwrite;
			wrAddr    <= haddr[7:0];
			if (addrPhase && !hwrite) begin
				hrdata <= 32'h0000_0000;
				unique case (haddr[7:6])
					QSS_WIN_CMD: hrdata <= {24'h00_0000, cmdRam[haddr[5:2]]};
					QSS_WIN_TX: hrdata <= 32'(txRam[haddr[5:2]]);
					QSS_WIN_RX: hrdata <= 32'(rxRam[haddr[5:2]]);
					default: begin
						unique case (haddr[7:0])
							QSS_OFS_CTRL_ONE: hrdata <= {30'h0, masterSelect, serialEnable};
							QSS_OFS_CTRL_TWO: hrdata <= {16'h0000, doneIrqEnable, wrapEnable,
								wrapTarget, 1'b0, endPtr, 4'h0, startPtr};
							QSS_OFS_CTRL_THREE: hrdata <= {29'h0, loopbackEnable,
								haltFaultIrqEnable, halt};
							QSS_OFS_STATUS: hrdata <= {24'h00_0000, flags[QSS_F_DONE],
								flags[QSS_F_FAULT], flags[QSS_F_HALT_ACK_FLAG], 1'b0, cptPtr};
							QSS_OFS_PORT: hrdata <= {28'h000_0000, portData};
							QSS_OFS_DIR: hrdata <= {28'h000_0000, pinDir};
							default: hrdata <= 32'h0000_0000;
						endcase
					end
				endcase
			end
		end
	end

	// Software-written control
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			masterSelect       <= 1'b0;
			startPtr           <= QSS_RST_PTR;
			endPtr             <= QSS_RST_PTR;
			wrapTarget         <= 1'b0;
			wrapEnable         <= 1'b0;
			doneIrqEnable      <= 1'b0;
			halt               <= 1'b0;
			haltFaultIrqEnable <= 1'b0;
			loopbackEnable     <= 1'b0;
			portData           <= QSS_RST_PORT;
			pinDir             <= QSS_RST_DIR;
		end else if (wrPend) begin
			unique case (wrAddr)
				QSS_OFS_CTRL_ONE: masterSelect <= hwdata[QSS_C1_MASTER];
				QSS_OFS_CTRL_TWO: begin
					startPtr      <= hwdata[QSS_C2_START_LSB +: 4];
					endPtr        <= hwdata[QSS_C2_END_LSB +: 4];
					wrapTarget    <= hwdata[QSS_C2_WRAP_TO];
					wrapEnable    <= hwdata[QSS_C2_WRAP_EN];
					doneIrqEnable <= hwdata[QSS_C2_DONE_IE];
				end
				QSS_OFS_CTRL_THREE: begin
					halt               <= hwdata[QSS_C3_HALT];
					haltFaultIrqEnable <= hwdata[QSS_C3_HFIE];
					loopbackEnable     <= hwdata[QSS_C3_LOOP];
				end
				QSS_OFS_PORT: portData <= hwdata[3:0];
				QSS_OFS_DIR: pinDir <= hwdata[3:0];
				default: ;
			endcase
		end
	end

	// Queue memories; receive words written by the sequencer only
	always_ff @(posedge core_clk) begin
		if (wrPend && wrAddr[7:6] == QSS_WIN_CMD) begin
			cmdRam[wrAddr[5:2]] <= hwdata[7:0];
		end
		if (wrPend && wrAddr[7:6] == QSS_WIN_TX) begin
			txRam[wrAddr[5:2]] <= hwdata[BITS-1:0];
		end
		if (shDone) begin
			rxRam[curIdx] <= shRx;
		end
	end

	// Hardware clear wins over a software set
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			serialEnable <= 1'b0;
		end else if (hwDisable) begin
			serialEnable <= 1'b0;
		end else if (wrPend && wrAddr == QSS_OFS_CTRL_ONE) begin
			serialEnable <= hwdata[QSS_C1_ENABLE];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			startPending <= 1'b0;
		end else if (wrStart && state != QSS_IDLE) begin
			startPending <= 1'b1;
		end else if (state == QSS_FINISH || state == QSS_IDLE) begin
			startPending <= 1'b0;
		end
	end

	// Sequencer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state    <= QSS_IDLE;
			curIdx   <= QSS_RST_PTR;
			lastPcs  <= 4'h0;
			lastHold <= 1'b0;
		end else if (!serialEnable || faultEvent) begin
			state <= QSS_IDLE;
		end else begin
			unique case (state)
				QSS_IDLE: begin
					if (masterSelect) begin
						curIdx <= startPtr;
						state  <= QSS_LOAD;
					end
				end
				QSS_LOAD: state <= QSS_SHIFT;
				QSS_SHIFT: begin
					if (shDone) begin
						lastPcs  <= curCmd[3:0];
						lastHold <= curCmd[QSS_CMD_HOLD];
						state    <= QSS_FINISH;
					end
				end
				QSS_FINISH: begin
					if (stopping) begin
						state <= QSS_IDLE;
					end else begin
						curIdx <= nextIdx;
						state  <= halt ? QSS_HALTED : QSS_LOAD;
					end
				end
				QSS_HALTED: begin
					if (!halt) begin
						state <= QSS_LOAD;
					end
				end
				default: state <= QSS_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cptPtr <= QSS_RST_PTR;
		end else if (state == QSS_FINISH) begin
			cptPtr <= curIdx;
		end
	end

	// Status flags: set wins over the read-then-write-zero clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			flags <= 3'h0;
			seen  <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (stsWrite && seen[i] && !hwdata[QSS_ST_HALT_ACK_FLAG + i]) begin
					flags[i] <= 1'b0;
				end
			end
			if (stsRead) begin
				seen <= flags;
			end else if (stsWrite) begin
				seen <= 3'h0;
			end
			if (state == QSS_FINISH && isLast && serialEnable && !faultEvent) begin
				flags[QSS_F_DONE] <= 1'b1;
			end
			if (state == QSS_FINISH && halt && serialEnable && !faultEvent) begin
				flags[QSS_F_HALT_ACK_FLAG] <= 1'b1;
			end
			if (faultEvent) begin
				flags[QSS_F_FAULT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= (flags[QSS_F_DONE] && doneIrqEnable) || (haltFaultIrqEnable &&
				(flags[QSS_F_HALT_ACK_FLAG] || flags[QSS_F_FAULT]));
		end
	end

	// Pins: port data when off, command pattern while shifting
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pcsOut  <= QSS_RST_PORT;
			pcsOe   <= QSS_RST_DIR;
			sckOut  <= 1'b0;
			mosiOut <= 1'b0;
		end else begin
			pcsOe   <= pinDir;
			sckOut  <= shSck;
			mosiOut <= shMosi;
			if (!serialEnable || state == QSS_IDLE) begin
				pcsOut <= portData;
			end else if (state == QSS_LOAD || state == QSS_SHIFT) begin
				pcsOut <= curCmd[3:0];
			end else begin
				pcsOut <= lastHold ? lastPcs : portData;
			end
		end
	end

	assign shStart = (state == QSS_LOAD);

	qss_shifter #(.BITS(BITS), .HALF(HALF)) u_qss_shifter (
		.core_clk (core_clk),
		.rstn     (rstn),
		.start    (shStart),
		.abort    (!serialEnable),
		.loopback (loopbackEnable),
		.txWord   (txRam[curIdx]),
		.rxPin    (misoSync),
		.sck      (shSck),
		.mosi     (shMosi),
		.busy     (shBusy),
		.done     (shDone),
		.rxWord   (shRx)
	);

	chk_done_on_end: assert property (@(posedge core_clk) disable iff (!rstn)
		state == QSS_FINISH && isLast && serialEnable && !faultEvent |=> flags[QSS_F_DONE])
		else $error("Done flag missing at end entry");
	chk_fault_disables: assert property (@(posedge core_clk) disable iff (!rstn)
		faultEvent |=> !serialEnable && state == QSS_IDLE && flags[QSS_F_FAULT])
		else $error("Mode fault did not disable");
	chk_fault_output_pin: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(flags[QSS_F_FAULT]) |-> !$past(pinDir[0]))
		else $error("Fault raised with select as output");
	chk_cpt_after_finish: assert property (@(posedge core_clk) disable iff (!rstn)
		cptPtr != $past(cptPtr) |-> $past(state) == QSS_FINISH)
		else $error("Completed pointer moved early");
	chk_irq_gated: assert property (@(posedge core_clk) disable iff (!rstn)
		!haltFaultIrqEnable && !doneIrqEnable |=> !irq)
		else $error("Interrupt without enable");
	chk_halt_stop: assert property (@(posedge core_clk) disable iff (!rstn)
		state == QSS_FINISH && halt && !isLast && serialEnable && !faultEvent
		|=> state == QSS_HALTED && flags[QSS_F_HALT_ACK_FLAG] && serialEnable)
		else $error("Halt did not reach halted state");
	chk_halt_last: assert property (@(posedge core_clk) disable iff (!rstn)
		state == QSS_FINISH && halt && isLast && serialEnable
		|=> !serialEnable && flags[QSS_F_DONE] && flags[QSS_F_HALT_ACK_FLAG])
		else $error("Halt at last entry not handled");
	chk_wrap_target: assert property (@(posedge core_clk) disable iff (!rstn)
		state == QSS_FINISH && isLast && wrapEnable && wrapTarget && !halt && !startPending
		&& serialEnable && !faultEvent |=> curIdx == $past(startPtr) && state == QSS_LOAD)
		else $error("Wrap did not jump to start");
	chk_flag_holds: assert property (@(posedge core_clk) disable iff (!rstn)
		flags[QSS_F_DONE] && !stsWrite |=> flags[QSS_F_DONE])
		else $error("Done flag lost without clear");
	chk_halted_link_idle: assert property (@(posedge core_clk) disable iff (!rstn)
		state == QSS_HALTED |-> !shBusy)
		else $error("Serializer busy while halted");
endmodule : qss_sequencer
`default_nettype wire

// *** core/qss_pkg.sv ***
// Constants of the queued serial sequencer: register map, field layout, timing.
// Assumes a 250 MHz core clock and a 32-bit AHB-Lite register port.
package qss_pkg;
	// Register byte offsets and queue window codes (address bits 7:6)
	localparam logic [7:0] QSS_OFS_CTRL_ONE   = 8'h00;
	localparam logic [7:0] QSS_OFS_CTRL_TWO   = 8'h04;
	localparam logic [7:0] QSS_OFS_CTRL_THREE = 8'h08;
	localparam logic [7:0] QSS_OFS_STATUS     = 8'h0C;
	localparam logic [7:0] QSS_OFS_PORT       = 8'h10;
	localparam logic [7:0] QSS_OFS_DIR        = 8'h14;
	localparam logic [1:0] QSS_WIN_CMD        = 2'h1;
	localparam logic [1:0] QSS_WIN_TX         = 2'h2;
	localparam logic [1:0] QSS_WIN_RX         = 2'h3;
	// Control one fields
	localparam int QSS_C1_ENABLE = 0;
	localparam int QSS_C1_MASTER = 1;
	// Control two fields
	localparam int QSS_C2_START_LSB = 0;
	localparam int QSS_C2_END_LSB   = 8;
	localparam int QSS_C2_WRAP_TO   = 13;
	localparam int QSS_C2_WRAP_EN   = 14;
	localparam int QSS_C2_DONE_IE   = 15;
	// Control three fields
	localparam int QSS_C3_HALT = 0;
	localparam int QSS_C3_HFIE = 1;
	localparam int QSS_C3_LOOP = 2;
	// Status fields
	localparam int QSS_ST_CPT_LSB = 0;
	localparam int QSS_ST_HALT_ACK_FLAG   = 5;
	localparam int QSS_ST_FAULT   = 6;
	localparam int QSS_ST_DONE    = 7;
	// Flag vector positions
	localparam int QSS_F_HALT_ACK_FLAG = 0;
	localparam int QSS_F_FAULT = 1;
	localparam int QSS_F_DONE  = 2;
	// Command byte fields
	localparam int QSS_CMD_HOLD = 7;
	// Reset values
	localparam logic [3:0]  QSS_RST_PTR  = 4'h0;
	localparam logic [3:0]  QSS_RST_PORT = 4'h0;
	localparam logic [3:0]  QSS_RST_DIR  = 4'h0;
	// Geometry
	localparam int QSS_ENTRIES = 16;
	localparam int QSS_BITS    = 16;
	// Serial clock timing
	localparam int QSS_CLK_PERIOD_NS = 4;
	localparam int QSS_SCK_PERIOD_NS = 80;
	localparam int QSS_SCK_HALF_CYCLES = QSS_SCK_PERIOD_NS / (2 * QSS_CLK_PERIOD_NS);
	typedef enum logic [2:0] {
		QSS_IDLE   = 3'h0,
		QSS_LOAD   = 3'h1,
		QSS_SHIFT  = 3'h3,
		QSS_FINISH = 3'h2,
		QSS_HALTED = 3'h6
	} qss_state_type;
endpackage : qss_pkg

// *** core/qss_shifter.sv ***
// Serializer of one transfer: SCK divider, MSB first, sample on the rising edge.
// Assumes the receive pin is already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
module qss_shifter import qss_pkg::*; #(
	parameter int BITS = QSS_BITS,
	parameter int HALF = QSS_SCK_HALF_CYCLES
) (
	input  wire logic            core_clk,
	input  wire logic            rstn,
	input  wire logic            start,
	input  wire logic            abort,
	input  wire logic            loopback,
	input  wire logic [BITS-1:0] txWord,
	input  wire logic            rxPin,
	output logic                 sck,
	output logic                 mosi,
	output logic                 busy,
	output logic                 done,
	output logic [BITS-1:0]      rxWord
);
	logic [15:0]     divCnt;
	logic [4:0]      bitCnt;
	logic [BITS-1:0] shiftTx;
	logic [BITS-1:0] shiftRx;
	logic            rxBit;

	assign rxBit = loopback ? mosi : rxPin;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy    <= 1'b0;
			done    <= 1'b0;
			sck     <= 1'b0;
			mosi    <= 1'b0;
			divCnt  <= 16'h0000;
			bitCnt  <= 5'h00;
			shiftTx <= '0;
			shiftRx <= '0;
			rxWord  <= '0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
				sck  <= 1'b0;
			end else if (start && !busy) begin
				busy    <= 1'b1;
				sck     <= 1'b0;
				shiftTx <= txWord;
				mosi    <= txWord[BITS-1];
				divCnt  <= 16'h0000;
				bitCnt  <= 5'h00;
			end else if (busy) begin
				if (divCnt == 16'(HALF - 1)) begin
					divCnt <= 16'h0000;
					sck    <= ~sck;
					if (!sck) begin
						shiftRx <= {shiftRx[BITS-2:0], rxBit};
					end else if (bitCnt == 5'(BITS - 1)) begin
						busy   <= 1'b0;
						done   <= 1'b1;
						rxWord <= shiftRx;
					end else begin
						bitCnt  <= bitCnt + 5'h01;
						shiftTx <= {shiftTx[BITS-2:0], 1'b0};
						mosi    <= shiftTx[BITS-2];
					end
				end else begin
					divCnt <= divCnt + 16'h0001;
				end
			end
		end
	end

	chk_idle_sck_low: assert property (@(posedge core_clk) disable iff (!rstn)
		!busy |-> !sck) else $error("SCK high while serializer idle");
	chk_done_after_busy: assert property (@(posedge core_clk) disable iff (!rstn)
		done |-> $past(busy) && !busy) else $error("Done without transfer");
endmodule : qss_shifter
`default_nettype wire

// *** sim/qss_spi_peer.sv ***
// Serial peripheral on the far side: mode 0, reports each 16-bit word it receives.
// Assumes chip select low while addressed; released line toggles every clock.
`timescale 1ns/1ps
`default_nettype none
module qss_spi_peer (
	input  wire logic        clk,
	input  wire logic        selN,
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic [15:0] reply,
	output logic             miso,
	output logic             frame,
	output logic      [15:0] word
);
	logic        sckD;
	logic [15:0] sh;
	logic [15:0] rx;
	int          n;
	initial begin
		miso = 1'b0;
		frame = 1'b0;
		word = 16'h0;
		sckD = 1'b0;
		sh = 16'h0;
		rx = 16'h0;
		n = 0;
	end
	always @(posedge clk) begin
		sckD <= sck;
		frame <= 1'b0;
		if (selN) begin
			// Released line must not keep the last bit
			miso <= ~miso;
			n <= 0;
			sh <= reply;
		end else begin
			miso <= sh[15];
			if (sck && !sckD) begin
				rx <= {rx[14:0], mosi};
				if (n == 15) begin
					word <= {rx[14:0], mosi};
					frame <= 1'b1;
					n <= 0;
				end else begin
					n <= n + 1;
				end
			end
			if (!sck && sckD) begin
				sh <= (n == 0) ? reply : {sh[14:0], 1'b0};
			end
		end
	end
endmodule : qss_spi_peer
`default_nettype wire

// *** sim/queued_spi_sequencer_status_test.sv ***
// Self-checking bench of the queue sequencer: registers over AHB-Lite, peer on the pins.
// Assumes the sequencer's zero-wait slave and default serial clock divider.
`timescale 1ns/1ps
`default_nettype none
module queued_spi_sequencer_status_test;
	import qss_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        ssExt = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        mosi;
	logic        sck;
	logic        irq;
	logic        miso;
	logic        frame;
	logic [3:0]  pcsOut;
	logic [3:0]  pcsOe;
	logic [15:0] word;
	logic [15:0] reply;
	logic [15:0] tx [16];
	logic [15:0] expQ [$];
	int          errCount = 0;
	int          cmpCount = 0;
	int          seed = 32'h45686833;
	wire         ssWire = pcsOe[0] ? pcsOut[0] : ssExt;
	always #2 clk = ~clk;
	qss_sequencer u_qss_sequencer (
		.core_clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pcsOut(pcsOut),
		.pcsOe(pcsOe), .slaveSelectIn(ssWire), .misoIn(miso), .mosiOut(mosi),
		.sckOut(sck), .irq(irq)
	);
	qss_spi_peer u_qss_spi_peer (
		.clk(clk), .selN(pcsOut[1]), .sck(sck), .mosi(mosi), .reply(reply),
		.miso(miso), .frame(frame), .word(word)
	);
	task automatic finishTest;
		if (errCount == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finishTest
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmpCount++;
		if (s !== e) begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(n, r, e);
	endtask : rc
	task automatic waitFlag(input int b);
		logic [31:0] r;
		do bus(1'b0, QSS_OFS_STATUS, 32'h0, r); while (r[b] !== 1'b1);
	endtask : waitFlag
	task automatic clr;
		logic [31:0] r;
		bus(1'b0, QSS_OFS_STATUS, 32'h0, r);
		wr(QSS_OFS_STATUS, 32'h0);
	endtask : clr
	task automatic waitSck;
		do @(posedge clk); while (sck !== 1'b1);
	endtask : waitSck
	task automatic start(input logic [31:0] c2);
		wr(QSS_OFS_CTRL_TWO, c2);
		wr(QSS_OFS_CTRL_ONE, 32'h3);
	endtask : start
	task automatic go(input int s, input int e, input logic [31:0] c2);
		int i;
		i = s;
		forever begin
			expQ.push_back(tx[i]);
			if (i == e)
				break;
			i = (i + 1) % QSS_ENTRIES;
		end
		start(c2 | (32'(e) << 8) | 32'(s));
	endtask : go
	always @(posedge clk) begin
		if (frame) begin
			if (expQ.size() == 0)
				chk("extra frame", 32'h1, 32'h0);
			else
				chk("frame", word, expQ.pop_front());
		end
	end
	initial begin
		repeat (40000) @(posedge clk);
		errCount++;
		finishTest;
	end
	initial begin
		for (int i = 0; i < QSS_ENTRIES; i++)
			tx[i] = 16'($random(seed));
		reply = 16'($random(seed));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rc("ctrl three", QSS_OFS_CTRL_THREE, 32'h0);
		rc("status", QSS_OFS_STATUS, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rc("unmapped", 8'h30, 32'h0);
		chk("okay resp", hresp, 32'h0);
		wr(QSS_OFS_PORT, 32'hE);
		wr(QSS_OFS_DIR, 32'hE);
		for (int i = 0; i < QSS_ENTRIES; i++) begin
			wr(8'h40 + 8'(4 * i), (i == 0) ? 32'h8C : 32'h0C);
			wr(8'h80 + 8'(4 * i), 32'(tx[i]));
		end
		chk("pin enables", pcsOe, 32'hE);
		// Sixteen entries wrapping past the top
		go(2, 1, 32'h8000);
		waitFlag(QSS_ST_DONE);
		chk("frames left", expQ.size(), 32'h0);
		chk("done irq", irq, 32'h1);
		rc("rx word", 8'hC4, 32'(reply));
		wr(QSS_OFS_STATUS, 32'hFF);
		wr(QSS_OFS_STATUS, 32'h0);
		rc("status kept", QSS_OFS_STATUS, 32'h81);
		wr(QSS_OFS_STATUS, 32'h0);
		rc("status cleared", QSS_OFS_STATUS, 32'h1);
		chk("irq cleared", irq, 32'h0);
		// Loopback
		wr(QSS_OFS_CTRL_THREE, 32'h4);
		go(3, 3, 32'h0);
		waitFlag(QSS_ST_DONE);
		rc("loop rx", 8'hCC, 32'(tx[3]));
		wr(QSS_OFS_CTRL_THREE, 32'h0);
		clr;
		// Both pointers rewritten during entry 0
		expQ = {tx[0], tx[8], tx[9]};
		start(32'h0300);
		waitSck;
		wr(QSS_OFS_CTRL_TWO, 32'h0908);
		waitFlag(QSS_ST_DONE);
		rc("repoint end", QSS_OFS_STATUS, 32'h89);
		clr;
		// Halt in mid queue with select held
		go(0, 2, 32'h0);
		waitSck;
		wr(QSS_OFS_CTRL_THREE, 32'h1);
		waitFlag(QSS_ST_HALT_ACK_FLAG);
		rc("halt status", QSS_OFS_STATUS, 32'h20);
		chk("held select", pcsOut, 32'hC);
		chk("irq gated", irq, 32'h0);
		chk("frames held", expQ.size(), 32'h2);
		wr(QSS_OFS_CTRL_THREE, 32'h0);
		waitFlag(QSS_ST_DONE);
		clr;
		// Halt during the last entry
		go(5, 5, 32'h0);
		waitSck;
		wr(QSS_OFS_CTRL_THREE, 32'h1);
		waitFlag(QSS_ST_HALT_ACK_FLAG);
		rc("last halt", QSS_OFS_STATUS, 32'hA5);
		rc("halt enable", QSS_OFS_CTRL_ONE, 32'h2);
		wr(QSS_OFS_CTRL_THREE, 32'h0);
		clr;
		// Wrap to start pointer, then wrap off; rewrite restarts at start pointer
		expQ = {tx[10], tx[11], tx[10], tx[10], tx[11]};
		start(32'h6B0A);
		waitFlag(QSS_ST_DONE);
		clr;
		wr(QSS_OFS_CTRL_TWO, 32'h0B0A);
		waitFlag(QSS_ST_DONE);
		rc("wrap end", QSS_OFS_STATUS, 32'h8B);
		chk("wrap frames", expQ.size(), 32'h0);
		clr;
		// Slave select as output, then as input pulled low
		wr(QSS_OFS_CTRL_THREE, 32'h2);
		wr(QSS_OFS_DIR, 32'hF);
		ssExt <= 1'b0;
		go(6, 6, 32'h0);
		waitFlag(QSS_ST_DONE);
		rc("no fault", QSS_OFS_STATUS, 32'h86);
		clr;
		wr(QSS_OFS_DIR, 32'hE);
		start(32'h0707);
		repeat (20) @(posedge clk);
		rc("fault", QSS_OFS_STATUS, 32'h46);
		rc("fault enable", QSS_OFS_CTRL_ONE, 32'h2);
		chk("pins to port", pcsOut, 32'hE);
		chk("fault irq", irq, 32'h1);
		ssExt <= 1'b1;
		clr;
		chk("queue empty", expQ.size(), 32'h0);
		finishTest;
	end
endmodule : queued_spi_sequencer_status_test
`default_nettype wire
